// ### hw/ifad_pkg.sv
// constants and carriers for the instruction format and add decoder
// ****************************************************************
// Overview of operation
// (RULE1) extended op word: 6-bit opcode, 4-bit op number, 2-bit mode, 4-bit register
// (RULE2) extended op number is read as a plain value 0 to 15
// (RULE3) source mode 10 makes the instruction two words, second is source address
// (RULE4) multiply/divide reuse the op number field as first result register
// (RULE5) source operand is the multiplier or the divisor; divide is only decoded here, no quotient is computed
// (RULE6) product high half to named register, low half to the next one
// (RULE7) map load: 11-bit opcode, one map select bit, 4-bit register
// (RULE8) map load reads six words from register-held address into chosen map
// (RULE9) word add base code a000, byte add base code b000
// (RULE10) word add writes source plus destination to destination, source kept
// (RULE11) logical, arithmetic greater and equal flags compare result with zero
// (RULE12) word add sets carry out of msb and overflow on signed 16-bit overflow
// (RULE13) byte add uses leftmost byte of a workspace register operand
// (RULE14) byte add sets carry out of byte msb and signed 8-bit overflow
// (RULE15) byte add sets odd parity flag when result byte has odd ones count
// (RULE16) byte add updates six flags, word add the same five without parity
// (RULE17) status bits untouched by an add keep their old values
// ****************************************************************
package ifad_pkg;
    // status word bit positions, bit 15 is the leftmost flag
    localparam int ST_LGT = 15;
    localparam int ST_AGT = 14;
    localparam int ST_EQ  = 13;
    localparam int ST_C   = 12;
    localparam int ST_OVF = 11;
    localparam int ST_OP  = 10;
    // base opcodes
    localparam logic [5:0]  OP_MUL = 6'h0e;
    localparam logic [5:0]  OP_DIV = 6'h0f;
    localparam logic [3:0]  OP_ADDW = 4'ha;
    localparam logic [3:0]  OP_ADDB = 4'hb;
    localparam logic [1:0]  MODE_SYMADDR = 2'h2;
    // decoded instruction kinds
    localparam logic [2:0]  K_NONE = 3'h0;
    localparam logic [2:0]  K_EXT  = 3'h1;
    localparam logic [2:0]  K_MUL  = 3'h2;
    localparam logic [2:0]  K_DIV  = 3'h3;
    localparam logic [2:0]  K_MAP  = 3'h4;
    localparam logic [2:0]  K_ADDW = 3'h5;
    localparam logic [2:0]  K_ADDB = 3'h6;
    localparam int          MAP_WORDS_DEF = 6;
    localparam logic [15:0] ZERO_W = 16'h0000;
    localparam logic [15:0] ADDR_STEP = 16'h0002;

    // fields of the extended-operation layout
    typedef struct packed {
        logic [5:0] op6;
        logic [3:0] ext_num;
        logic [1:0] src_mode;
        logic [3:0] src_reg;
    } ifad_fields_t;

    // result word and its status word
    typedef struct packed {
        logic [15:0] res;
        logic [15:0] st;
    } ifad_alu_t;
endpackage : ifad_pkg

// ### hw/ifad_decode.sv
// decoder for extended op, multiply/divide, map load and adds; executes only multiply, map load and adds
`timescale 1ns/100ps
`default_nettype none
module ifad_decode #(
    parameter logic [5:0]  EXT_OP    = 6'h0a,  // arbitrary default
    parameter logic [10:0] MAP_OP    = 11'h001, // arbitrary default
    parameter int          MAP_WORDS = ifad_pkg::MAP_WORDS_DEF
) (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  nrst_i,
    // instruction and operands from the sequencer
    input  wire logic                  instr_valid_i,
    input  wire logic [15:0]           instr_i,
    input  wire logic [15:0]           src_opnd_i,
    input  wire logic [15:0]           dst_opnd_i,
    input  wire logic [15:0]           wreg_opnd_i,
    input  wire logic [15:0]           status_i,
    // memory read return
    input  wire logic [15:0]           mem_rdata_i,
    input  wire logic                  mem_rvalid_i,
    // decode results
    output logic                       busy_o,
    output logic                       done_o,
    output logic [2:0]                 kind_o,
    output ifad_pkg::ifad_fields_t     fields_o,
    output logic                       need_word2_o,
    output logic [3:0]                 dst_reg_o,
    output logic [3:0]                 dst_reg2_o,
    output logic                       dst_wrap_o,
    // write-back
    output logic [15:0]                res1_o,
    output logic [15:0]                res2_o,
    output logic                       res1_we_o,
    output logic                       res2_we_o,
    output logic [15:0]                status_o,
    output logic                       status_we_o,
    // memory read request and map file write
    output logic                       mem_rd_o,
    output logic [15:0]                mem_addr_o,
    output logic                       map_we_o,
    output logic                       map_sel_o,
    output logic [2:0]                 map_idx_o,
    output logic [15:0]                map_data_o
);
    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (MAP_WORDS < 1 || MAP_WORDS > 8) begin : g_chk
        $error("MAP_WORDS must be 1 to 8");
    end

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    // two stages so release is clean against the clock
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ****************************************************************
    // arithmetic
    // ****************************************************************
    typedef enum logic [1:0] {S_IDLE = 2'b01, S_WAIT = 2'b10} ifad_state_t;

    ifad_pkg::ifad_alu_t add_w, add_b;
    logic [16:0] sum_w;
    logic [8:0]  sum_b;
    logic [31:0] prod;

    // word add and byte add with their flags
    always_comb begin
        sum_w = {1'b0, src_opnd_i} + {1'b0, dst_opnd_i};
        sum_b = {1'b0, src_opnd_i[15:8]} + {1'b0, dst_opnd_i[15:8]}; // see (RULE13)
        add_w.res = sum_w[15:0];                                      // see (RULE10)
        add_w.st  = status_i;                                         // see (RULE17)
        add_w.st[ifad_pkg::ST_LGT] = sum_w[15:0] != ifad_pkg::ZERO_W; // see (RULE11)
        add_w.st[ifad_pkg::ST_AGT] = !sum_w[15] && sum_w[15:0] != ifad_pkg::ZERO_W;
        add_w.st[ifad_pkg::ST_EQ]  = sum_w[15:0] == ifad_pkg::ZERO_W;
        add_w.st[ifad_pkg::ST_C]   = sum_w[16];                       // see (RULE12)
        add_w.st[ifad_pkg::ST_OVF] = (src_opnd_i[15] == dst_opnd_i[15])
                                     && (sum_w[15] != src_opnd_i[15]);
        // low byte of the destination word rides through untouched
        add_b.res = {sum_b[7:0], dst_opnd_i[7:0]};                    // see (RULE13)
        add_b.st  = status_i;                                         // see (RULE16)
        add_b.st[ifad_pkg::ST_LGT] = sum_b[7:0] != 8'h00;             // see (RULE11)
        add_b.st[ifad_pkg::ST_AGT] = !sum_b[7] && sum_b[7:0] != 8'h00;
        add_b.st[ifad_pkg::ST_EQ]  = sum_b[7:0] == 8'h00;
        add_b.st[ifad_pkg::ST_C]   = sum_b[8];                        // see (RULE14)
        add_b.st[ifad_pkg::ST_OVF] = (src_opnd_i[15] == dst_opnd_i[15])
                                     && (sum_b[7] != src_opnd_i[15]);
        add_b.st[ifad_pkg::ST_OP]  = ^sum_b[7:0];                     // see (RULE15)
        prod = src_opnd_i * dst_opnd_i;                               // see (RULE5)
    end

    // ****************************************************************
    // decode, execute and map load sequence
    // ****************************************************************
    ifad_state_t           state_reg, state_next;
    logic                  done_reg, done_next;
    logic [2:0]            kind_reg, kind_next;
    ifad_pkg::ifad_fields_t fld_reg, fld_next;
    logic                  w2_reg, w2_next;
    logic [3:0]            dr_reg, dr_next, dr2_reg, dr2_next;
    logic                  wrap_reg, wrap_next;
    logic [15:0]           r1_reg, r1_next, r2_reg, r2_next;
    logic                  r1we_reg, r1we_next, r2we_reg, r2we_next;
    logic [15:0]           st_reg, st_next;
    logic                  stwe_reg, stwe_next;
    logic                  rd_reg, rd_next;
    logic [15:0]           addr_reg, addr_next;
    logic                  mwe_reg, mwe_next, msel_reg, msel_next;
    logic [2:0]            cnt_reg, cnt_next;
    logic [15:0]           mdat_reg, mdat_next;
    logic                  take;

    assign take = instr_valid_i && state_reg == S_IDLE;

    // next values; pulses drop unless renewed this cycle
    always_comb begin
        state_next = state_reg;
        done_next  = 1'b0;
        kind_next  = kind_reg;
        fld_next   = fld_reg;
        w2_next    = w2_reg;
        dr_next    = dr_reg;
        dr2_next   = dr2_reg;
        wrap_next  = wrap_reg;
        r1_next    = r1_reg;
        r2_next    = r2_reg;
        r1we_next  = 1'b0;
        r2we_next  = 1'b0;
        st_next    = st_reg;
        stwe_next  = 1'b0;
        rd_next    = 1'b0;
        addr_next  = addr_reg;
        mwe_next   = 1'b0;
        msel_next  = msel_reg;
        cnt_next   = cnt_reg;
        mdat_next  = mdat_reg;
        case (state_reg)
            S_IDLE: begin
                if (take) begin
                    fld_next = instr_i;                               // see (RULE1)
                    w2_next  = instr_i[5:4] == ifad_pkg::MODE_SYMADDR; // see (RULE3)
                    dr_next  = instr_i[9:6];                          // see (RULE4)
                    dr2_next = instr_i[9:6] + 4'h1;
                    wrap_next = instr_i[9:6] == 4'hf;
                    kind_next = ifad_pkg::K_NONE;
                    done_next = 1'b1;
                    if (instr_i[15:12] == ifad_pkg::OP_ADDW) begin    // see (RULE9)
                        kind_next = ifad_pkg::K_ADDW;
                        r1_next   = add_w.res;
                        st_next   = add_w.st;
                        r1we_next = 1'b1;
                        stwe_next = 1'b1;
                    end else if (instr_i[15:12] == ifad_pkg::OP_ADDB) begin
                        kind_next = ifad_pkg::K_ADDB;
                        r1_next   = add_b.res;
                        st_next   = add_b.st;
                        r1we_next = 1'b1;
                        stwe_next = 1'b1;
                    end else if (instr_i[15:10] == ifad_pkg::OP_MUL) begin
                        kind_next = ifad_pkg::K_MUL;
                        r1_next   = prod[31:16];                      // see (RULE6)
                        r2_next   = prod[15:0];
                        r1we_next = 1'b1;
                        r2we_next = 1'b1;
                    end else if (instr_i[15:10] == ifad_pkg::OP_DIV) begin
                        kind_next = ifad_pkg::K_DIV;
                    end else if (instr_i[15:10] == EXT_OP) begin
                        kind_next = ifad_pkg::K_EXT;                  // see (RULE2)
                    end else if (instr_i[15:5] == MAP_OP) begin
                        kind_next  = ifad_pkg::K_MAP;                 // see (RULE7)
                        done_next  = 1'b0;
                        dr_next    = instr_i[3:0];
                        msel_next  = instr_i[4];
                        addr_next  = wreg_opnd_i;                     // see (RULE8)
                        rd_next    = 1'b1;
                        cnt_next   = 3'h0;
                        state_next = S_WAIT;
                    end
                end
            end
            S_WAIT: begin
                if (mem_rvalid_i) begin
                    mwe_next  = 1'b1;
                    mdat_next = mem_rdata_i;
                    if (cnt_reg == 3'(MAP_WORDS - 1)) begin           // see (RULE8)
                        done_next  = 1'b1;
                        state_next = S_IDLE;
                    end else begin
                        cnt_next  = cnt_reg + 3'h1;
                        addr_next = addr_reg + ifad_pkg::ADDR_STEP;
                        rd_next   = 1'b1;
                    end
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // the map index is registered beside the word it labels; stray returns are ignored
    logic [2:0] idx_reg, idx_next;
    assign idx_next = (mem_rvalid_i && state_reg == S_WAIT) ? cnt_reg : idx_reg;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            done_reg  <= 1'b0;
            kind_reg  <= ifad_pkg::K_NONE;
            fld_reg   <= '0;
            w2_reg    <= 1'b0;
            dr_reg    <= 4'h0;
            dr2_reg   <= 4'h0;
            wrap_reg  <= 1'b0;
            r1_reg    <= 16'h0000;
            r2_reg    <= 16'h0000;
            r1we_reg  <= 1'b0;
            r2we_reg  <= 1'b0;
            st_reg    <= 16'h0000;
            stwe_reg  <= 1'b0;
            rd_reg    <= 1'b0;
            addr_reg  <= 16'h0000;
            mwe_reg   <= 1'b0;
            msel_reg  <= 1'b0;
            cnt_reg   <= 3'h0;
            mdat_reg  <= 16'h0000;
            idx_reg   <= 3'h0;
        end else begin
            state_reg <= state_next;
            done_reg  <= done_next;
            kind_reg  <= kind_next;
            fld_reg   <= fld_next;
            w2_reg    <= w2_next;
            dr_reg    <= dr_next;
            dr2_reg   <= dr2_next;
            wrap_reg  <= wrap_next;
            r1_reg    <= r1_next;
            r2_reg    <= r2_next;
            r1we_reg  <= r1we_next;
            r2we_reg  <= r2we_next;
            st_reg    <= st_next;
            stwe_reg  <= stwe_next;
            rd_reg    <= rd_next;
            addr_reg  <= addr_next;
            mwe_reg   <= mwe_next;
            msel_reg  <= msel_next;
            cnt_reg   <= cnt_next;
            mdat_reg  <= mdat_next;
            idx_reg   <= idx_next;
        end
    end

    // outputs straight from flops
    assign busy_o       = state_reg[1];           // one-hot wait bit, no gate after the flop
    assign done_o       = done_reg;
    assign kind_o       = kind_reg;
    assign fields_o     = fld_reg;
    assign need_word2_o = w2_reg;
    assign dst_reg_o    = dr_reg;
    assign dst_reg2_o   = dr2_reg;
    assign dst_wrap_o   = wrap_reg;
    assign res1_o       = r1_reg;
    assign res2_o       = r2_reg;
    assign res1_we_o    = r1we_reg;
    assign res2_we_o    = r2we_reg;
    assign status_o     = st_reg;
    assign status_we_o  = stwe_reg;
    assign mem_rd_o     = rd_reg;
    assign mem_addr_o   = addr_reg;
    assign map_we_o     = mwe_reg;
    assign map_sel_o    = msel_reg;
    assign map_idx_o    = idx_reg;
    assign map_data_o   = mdat_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_map_go;
        take && instr_i[15:5] == MAP_OP;
    endsequence
    sequence s_any_go;
        take;
    endsequence

    AST_EXT_FIELDS: assert property ( // see (RULE1)
        s_any_go |=> fields_o.ext_num == $past(instr_i[9:6])
        && fields_o.src_reg == $past(instr_i[3:0])) else $error("field split wrong");
    AST_EXT_KIND: assert property ( // see (RULE2)
        s_any_go ##0 instr_i[15:10] == EXT_OP
        |=> kind_o == ifad_pkg::K_EXT) else $error("extended op missed");
    AST_TWO_WORD: assert property ( // see (RULE3)
        s_any_go |=> need_word2_o == ($past(instr_i[5:4]) == ifad_pkg::MODE_SYMADDR))
        else $error("two word flag");
    AST_MUL_REGS: assert property ( // see (RULE4)
        s_any_go ##0 instr_i[15:10] == ifad_pkg::OP_MUL
        |=> dst_reg_o == $past(instr_i[9:6])
            && dst_reg2_o == 4'($past(instr_i[9:6]) + 4'h1)
            && dst_wrap_o == ($past(instr_i[9:6]) == 4'hf)) else $error("multiply reg pair");
    AST_MUL_PROD: assert property ( // see (RULE6)
        s_any_go ##0 instr_i[15:10] == ifad_pkg::OP_MUL
        |=> {res1_o, res2_o} == $past(src_opnd_i) * $past(dst_opnd_i)
            && res1_we_o && res2_we_o) else $error("multiply product");
    AST_MAP_START: assert property ( // see (RULE7)
        s_map_go |=> mem_rd_o && busy_o
        && mem_addr_o == $past(wreg_opnd_i) && map_sel_o == $past(instr_i[4]))
        else $error("map load start");
    AST_MAP_END: assert property ( // see (RULE8)
        busy_o && mem_rvalid_i && cnt_reg == 3'(MAP_WORDS - 1)
        |=> map_we_o && done_o && !busy_o ##1 !map_we_o) else $error("map load end");
    // carry checked as unsigned wrap of the sum below its source operand
    AST_ADDW_SUM: assert property ( // see (RULE12)
        s_any_go ##0 instr_i[15:12] == ifad_pkg::OP_ADDW
        |=> res1_o == $past(src_opnd_i) + $past(dst_opnd_i) && !res2_we_o
            && status_o[ifad_pkg::ST_C] == (res1_o < $past(src_opnd_i))) else $error("word add");
    AST_ZERO_FLAG: assert property (done_o && kind_o == ifad_pkg::K_ADDW
        |-> status_o[ifad_pkg::ST_EQ] == (res1_o == ifad_pkg::ZERO_W)) else $error("eq flag"); // see (RULE11)
    AST_BYTE_PAR: assert property (done_o && kind_o == ifad_pkg::K_ADDB
        |-> status_o[ifad_pkg::ST_OP] == ^res1_o[15:8]) else $error("parity flag"); // see (RULE15)
    AST_KEEP_ST: assert property (s_any_go ##0 instr_i[15:13] == 3'h5
        |=> status_o[9:0] == $past(status_i[9:0])) else $error("other bits changed"); // see (RULE17)
endmodule : ifad_decode
`default_nettype wire

// ### verif/test_instr_format_add_decode.sv
// self-checking bench for the instruction format and add decoder
`timescale 1ns/100ps
`default_nettype none
module test_instr_format_add_decode;
    // ****************************************
    // stimulus, outputs and expectation notes
    // ****************************************
    localparam logic [5:0]  EXT_CODE = 6'h0a;
    localparam logic [10:0] MAP_CODE = 11'h001;
    typedef struct packed {
        logic [2:0]  kind;
        logic [2:0]  we;
        logic [15:0] ins;
        logic [15:0] r1;
        logic [15:0] r2;
        logic [15:0] st;
    } ifadtb_exp_t;
    logic                   core_clk_i, nrst_i, instr_valid_i, mem_rvalid_i;
    logic [15:0]            instr_i, src_opnd_i, dst_opnd_i, wreg_opnd_i, status_i, mem_rdata_i;
    logic                   busy_o, done_o, need_word2_o, dst_wrap_o, res1_we_o, res2_we_o;
    logic                   status_we_o, mem_rd_o, map_we_o, map_sel_o;
    logic [2:0]             kind_o, map_idx_o;
    logic [3:0]             dst_reg_o, dst_reg2_o;
    logic [15:0]            res1_o, res2_o, status_o, mem_addr_o, map_data_o;
    ifad_pkg::ifad_fields_t fields_o;
    ifadtb_exp_t            q_done[$];
    ifadtb_exp_t            e;
    logic [18:0]            q_map[$];
    logic [18:0]            m;
    logic [15:0]            map_addr, rd_data;
    logic [2:0]             map_n;
    logic                   map_sel_e;
    integer                 seed = 32'h8fa8;
    int                     n_fail = 0;
    int                     checked = 0;

    ifad_decode #(.EXT_OP(EXT_CODE), .MAP_OP(MAP_CODE), .MAP_WORDS(6)) i_ifad_decode (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .src_opnd_i(src_opnd_i), .dst_opnd_i(dst_opnd_i),
        .wreg_opnd_i(wreg_opnd_i), .status_i(status_i), .mem_rdata_i(mem_rdata_i),
        .mem_rvalid_i(mem_rvalid_i), .busy_o(busy_o), .done_o(done_o), .kind_o(kind_o),
        .fields_o(fields_o), .need_word2_o(need_word2_o), .dst_reg_o(dst_reg_o),
        .dst_reg2_o(dst_reg2_o), .dst_wrap_o(dst_wrap_o), .res1_o(res1_o), .res2_o(res2_o),
        .res1_we_o(res1_we_o), .res2_we_o(res2_we_o), .status_o(status_o),
        .status_we_o(status_we_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
        .map_we_o(map_we_o), .map_sel_o(map_sel_o), .map_idx_o(map_idx_o),
        .map_data_o(map_data_o));

    // 25 mhz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // valid is held across calls, so consecutive calls are back to back
    task automatic drive(input logic [15:0] ins, s, d, w, st);
        @(posedge core_clk_i);
        instr_valid_i <= 1'b1;
        instr_i       <= ins;
        src_opnd_i    <= s;
        dst_opnd_i    <= d;
        wreg_opnd_i   <= w;
        status_i      <= st;
    endtask : drive

    // bounded wait until every note has been matched
    task automatic drain(input string name);
        int n;
        n = 0;
        @(posedge core_clk_i);
        instr_valid_i <= 1'b0;
        while ((q_done.size() + q_map.size()) != 0 && n < 400) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n == 400) begin
            n_fail++;
            report_and_stop();
        end else begin
            repeat (2) @(posedge core_clk_i);
            $display("test %s ended", name);
        end
    endtask : drain

    // reference sum and flags; byte operands sit in bits 15:8
    function automatic ifadtb_exp_t add_exp(input logic [15:0] ins, s, d, st);
        logic [16:0] w;
        logic [8:0]  b;
        logic        byt;
        logic        z;
        ifadtb_exp_t r;
        byt = (ins[15:12] == ifad_pkg::OP_ADDB);
        w = {1'b0, s} + {1'b0, d};
        b = {1'b0, s[15:8]} + {1'b0, d[15:8]};
        r = '{ins: ins, r2: 16'h0000, we: 3'h5, st: st,
              kind: byt ? ifad_pkg::K_ADDB : ifad_pkg::K_ADDW,
              r1: byt ? {b[7:0], d[7:0]} : w[15:0]};
        z = byt ? (b[7:0] == 8'h00) : (w[15:0] == 16'h0000);
        r.st[ifad_pkg::ST_EQ]  = z;
        r.st[ifad_pkg::ST_LGT] = !z;
        r.st[ifad_pkg::ST_AGT] = !z && !r.r1[15];
        r.st[ifad_pkg::ST_C]   = byt ? b[8] : w[16];
        r.st[ifad_pkg::ST_OVF] = (s[15] == d[15]) && (r.r1[15] != s[15]);
        if (byt) begin
            r.st[ifad_pkg::ST_OP] = ^b[7:0];
        end
        return r;
    endfunction : add_exp

    // ****************************************
    // output watcher and memory responder
    // ****************************************
    always @(posedge core_clk_i) begin
        if (done_o === 1'b1) begin
            if (q_done.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                e = q_done.pop_front();
                chk(32'({kind_o, res1_we_o, res2_we_o, status_we_o}), 32'({e.kind, e.we}));
                chk(32'({fields_o, need_word2_o}), 32'({e.ins, e.ins[5:4] == 2'h2}));
                if (e.we[1]) begin
                    chk({res1_o, res2_o}, {e.r1, e.r2});
                    chk(32'({dst_reg_o, dst_reg2_o, dst_wrap_o}),
                        32'({e.ins[9:6], e.ins[9:6] + 4'h1, &e.ins[9:6]}));
                end else if (e.we[2]) begin
                    chk(32'(res1_o), 32'(e.r1));
                end
                if (e.we[0]) chk(32'(status_o), 32'(e.st));
                if (e.kind == ifad_pkg::K_MAP) chk(32'(dst_reg_o), 32'(e.ins[3:0]));
            end
        end
        if (map_we_o === 1'b1) begin
            m = (q_map.size() != 0) ? q_map.pop_front() : 19'h7ffff;
            chk(32'({map_sel_o, map_idx_o, map_data_o}), 32'({map_sel_e, m}));
        end
    end

    // answers each read one cycle later; data is scrambled when not valid
    always @(posedge core_clk_i) begin
        mem_rvalid_i <= (mem_rd_o === 1'b1);
        if (mem_rd_o === 1'b1) begin
            chk(32'(mem_addr_o), 32'(map_addr));
            rd_data = 16'($random(seed));
            mem_rdata_i <= rd_data;
            q_map.push_back({map_n, rd_data});
            map_n = map_n + 3'h1;
            map_addr = map_addr + ifad_pkg::ADDR_STEP;
        end else begin
            mem_rdata_i <= ~mem_rdata_i;
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [15:0] cs[4];
        logic [15:0] cd[4];
        logic [15:0] s, d, ins, st;
        logic [31:0] p;
        cs = '{16'h7fff, 16'hffff, 16'h7400, 16'h8000};
        cd = '{16'h0001, 16'h0100, 16'h1800, 16'h8000};
        {nrst_i, instr_valid_i, instr_i, src_opnd_i, dst_opnd_i} = '0;
        {wreg_opnd_i, status_i, mem_rdata_i, map_addr, map_n, map_sel_e} = '0;
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        // word then byte adds: corners first, then random operands
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 24; i++) begin
                s = (i < 4) ? cs[i] : 16'($random(seed));
                d = (i < 4) ? cd[i] : 16'($random(seed));
                st = 16'($random(seed));
                ins = {j ? ifad_pkg::OP_ADDB : ifad_pkg::OP_ADDW, 12'($random(seed))};
                drive(ins, s, d, 16'($random(seed)), st);
                q_done.push_back(add_exp(ins, s, d, st));
            end
        end
        drain("add");
        // multiply into every register pair, register 15 wraps
        for (int i = 0; i < 16; i++) begin
            s = (i == 15) ? 16'hffff : 16'($random(seed));
            d = (i == 15) ? 16'hffff : 16'($random(seed));
            p = {16'h0000, s} * {16'h0000, d};
            ins = {ifad_pkg::OP_MUL, 4'(i), 6'($random(seed))};
            drive(ins, s, d, 16'($random(seed)), 16'($random(seed)));
            q_done.push_back('{ifad_pkg::K_MUL, 3'h6, ins, p[31:16], p[15:0], 16'h0000});
        end
        drain("multiply");
        // every extended operation number and mode, then divide and unknown
        for (int i = 0; i < 18; i++) begin
            ins = (i == 16) ? {ifad_pkg::OP_DIV, 10'h0a5} :
                  (i == 17) ? 16'h0000 : {EXT_CODE, 4'(i), 2'(i), 4'(15 - i)};
            drive(ins, 16'($random(seed)), 16'($random(seed)), 16'h0000, 16'h0000);
            q_done.push_back('{(i == 16) ? ifad_pkg::K_DIV : (i == 17) ? ifad_pkg::K_NONE :
                ifad_pkg::K_EXT, 3'h0, ins, 16'h0000, 16'h0000, 16'h0000});
        end
        drain("extended");
        // map load into both files; adds offered while busy must be ignored
        for (int k = 0; k < 2; k++) begin
            ins = {MAP_CODE, 1'(k), 4'($random(seed))};
            map_addr = 16'($random(seed)) & 16'hfffe;
            map_n = 3'h0;
            map_sel_e = 1'(k);
            q_done.push_back('{ifad_pkg::K_MAP, 3'h0, ins, 16'h0000, 16'h0000, 16'h0000});
            drive(ins, 16'h0000, 16'h0000, map_addr, 16'h0000);
            repeat (3) drive(16'ha000, 16'h0001, 16'h0001, 16'h0000, 16'h0000);
            @(posedge core_clk_i);
            instr_valid_i <= 1'b0;
            chk(32'(busy_o), 32'h1);
            drain("map load");
            chk(32'(busy_o), 32'h0);
        end
        report_and_stop();
    end
endmodule : test_instr_format_add_decode
`default_nettype wire
